// >>> src/pfm_top.sv
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module pfm_top
	import pfm_pkg::*;
(
	input wire logic ref_clk, // 125 MHz system clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire pfm_bus_type bus_in, // Register port request
	output logic [7:0] rdata, // Read data, cycle after strobe
	input wire logic [7:0] pin_in, // Pad input levels
	output logic [7:0] pin_out, // Pad output levels
	output logic [7:0] pin_oe, // Pad output enables
	input wire logic low_power_mode, // Sleep or idle active
	output logic wake_req, // Wake-up pulse
	input wire pfm_periph_out_type periph_out, // Peripheral outputs
	output pfm_periph_in_type periph_in, // Peripheral inputs
	output pfm_analog_type analog_sel // Analogue/gate switches
);
	logic [7:0] data_q, dir_q, wake_q, sel_lo_q, sel_hi_q, src_q;
	logic [7:0] pin_s, pin_prev_q, drive_d, oe_d, rdata_d;
	logic [7:0] gpio_en, rmw_cur, rmw_new;
	logic [1:0] c0, c1, c2, c3, c4, c5, c6, c7;
	logic [1:0] rmw_tgt;
	logic [2:0] rmw_bit;
	logic rmw_set, rmw_go;
	pfm_periph_in_type pin_d;
	pfm_analog_type an_d;

	// Pad inputs come from outside the clock domain
	pfm_sync #(.WIDTH(8)) u_sync (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.async_in(pin_in),
		.sync_out(pin_s)
	);

	assign c0 = sel_lo_q[1:0];
	assign c1 = sel_lo_q[3:2];
	assign c2 = sel_lo_q[5:4];
	assign c3 = sel_lo_q[7:6];
	assign c4 = sel_hi_q[1:0];
	assign c5 = sel_hi_q[3:2];
	assign c6 = sel_hi_q[5:4];
	assign c7 = sel_hi_q[7:6];

	// Bit-op request fields
	assign rmw_go = bus_in.wr && (bus_in.addr == PFM_ADDR_BITOP);
	assign rmw_set = bus_in.wdata[PFM_BITOP_SET];
	assign rmw_tgt = bus_in.wdata[4:3];
	assign rmw_bit = bus_in.wdata[2:0];

	// Read whole port register, change one bit, write the byte back
	always_comb begin
		unique case (rmw_tgt)
			PFM_TGT_DATA: rmw_cur = port_view(data_q, dir_q, pin_s);
			PFM_TGT_DIR: rmw_cur = dir_q;
			PFM_TGT_WAKE: rmw_cur = wake_q;
			default: rmw_cur = 8'h00;
		endcase
		rmw_new = rmw_cur;
		rmw_new[rmw_bit] = rmw_set;
	end

	// Input pins read their level, output pins read the latch
	function automatic logic [7:0] port_view(input logic [7:0] lat,
		input logic [7:0] dir, input logic [7:0] lvl);
		port_view = (dir & lvl) | (~dir & lat);
	endfunction

	// Port data latch; reset high so a new output starts high
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			data_q <= PFM_RST_DATA;
		end else if (bus_in.wr && bus_in.addr == PFM_ADDR_DATA) begin
			data_q <= bus_in.wdata;
		end else if (rmw_go && rmw_tgt == PFM_TGT_DATA) begin
			data_q <= rmw_new;
		end
	end

	// Direction control, one means input
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dir_q <= PFM_RST_DIR;
		end else if (bus_in.wr && bus_in.addr == PFM_ADDR_DIR) begin
			dir_q <= bus_in.wdata;
		end else if (rmw_go && rmw_tgt == PFM_TGT_DIR) begin
			dir_q <= rmw_new;
		end
	end

	// Wake-up enables
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wake_q <= PFM_RST_WAKE;
		end else if (bus_in.wr && bus_in.addr == PFM_ADDR_WAKE) begin
			wake_q <= bus_in.wdata;
		end else if (rmw_go && rmw_tgt == PFM_TGT_WAKE) begin
			wake_q <= rmw_new;
		end
	end

	// Function selection registers
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sel_lo_q <= PFM_RST_SEL;
			sel_hi_q <= PFM_RST_SEL;
		end else if (bus_in.wr) begin
			if (bus_in.addr == PFM_ADDR_SEL_LO) begin
				sel_lo_q <= bus_in.wdata;
			end
			if (bus_in.addr == PFM_ADDR_SEL_HI) begin
				sel_hi_q <= bus_in.wdata;
			end
		end
	end

	// Input source select; only two bits exist
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			src_q <= PFM_RST_SRC;
		end else if (bus_in.wr && bus_in.addr == PFM_ADDR_SRC) begin
			src_q <= bus_in.wdata & PFM_SRC_MASK;
		end
	end

	// Pins whose code keeps them under general I/O; reserved counts too
	always_comb begin
		gpio_en[0] = (c0 == PFM_CODE_GPIO);
		gpio_en[1] = (c1 == PFM_CODE_GPIO);
		gpio_en[2] = (c2 == PFM_CODE_GPIO);
		gpio_en[3] = (c3 == PFM_CODE_GPIO) || (c3 == PFM_CODE_1);
		gpio_en[4] = (c4 == PFM_CODE_GPIO) || (c4 == PFM_CODE_3);
		gpio_en[5] = (c5 != PFM_CODE_3);
		gpio_en[6] = 1'b1;
		gpio_en[7] = (c7 != PFM_CODE_3);
	end

	// Output drive per pin: general I/O push-pull or peripheral out
	always_comb begin
		drive_d = data_q;
		oe_d = gpio_en & ~dir_q;
		unique case (c0)
			PFM_CODE_1: drive_d[0] = periph_out.compact_timer_out;
			PFM_CODE_2: drive_d[0] =
				periph_out.compact_timer_out_inverted;
			default: ;
		endcase
		if (c0 == PFM_CODE_1 || c0 == PFM_CODE_2) begin
			oe_d[0] = 1'b1;
		end
		if (c1 == PFM_CODE_1) begin
			drive_d[1] = periph_out.serial_tx;
			oe_d[1] = 1'b1;
		end
		unique case (c2)
			PFM_CODE_1: drive_d[2] = periph_out.standard_timer_out;
			PFM_CODE_2: drive_d[2] =
				periph_out.standard_timer_out_inverted;
			default: ;
		endcase
		if (c2 == PFM_CODE_1 || c2 == PFM_CODE_2) begin
			oe_d[2] = 1'b1;
		end
		if (c3 == PFM_CODE_2) begin
			drive_d[3] = periph_out.serial_tx;
			oe_d[3] = 1'b1;
		end
		if (c4 == PFM_CODE_2) begin
			drive_d[4] = periph_out.compact_timer_out_inverted;
			oe_d[4] = 1'b1;
		end
	end

	// Inputs toward peripherals; unselected inputs idle high
	always_comb begin
		pin_d.ext_interrupt_in = (c0 == PFM_CODE_GPIO) ? pin_s[0] : 1'b1;
		pin_d.periodic_timer_capture_in =
			(c3 == PFM_CODE_GPIO) ? pin_s[3] : 1'b1;
		pin_d.standard_timer_capture_in =
			(c2 == PFM_CODE_GPIO) ? pin_s[2] : 1'b1;
		pin_d.standard_timer_clock_in =
			(c1 == PFM_CODE_GPIO) ? pin_s[1] : 1'b1;
		pin_d.compact_timer_clock_in =
			(c4 == PFM_CODE_GPIO) ? pin_s[4] : 1'b1;
		if (src_q[PFM_SRC_NF_BIT]) begin
			pin_d.noise_filter_input =
				(c0 == PFM_CODE_GPIO) ? pin_s[0] : 1'b1;
		end else begin
			pin_d.noise_filter_input =
				(c1 == PFM_CODE_GPIO) ? pin_s[1] : 1'b1;
		end
		if (src_q[PFM_SRC_RX_BIT]) begin
			pin_d.serial_rx = (c4 == PFM_CODE_1) ? pin_s[4] : 1'b1;
		end else begin
			pin_d.serial_rx = (c1 == PFM_CODE_2) ? pin_s[1] : 1'b1;
		end
	end

	// Analogue and gate-driver switches
	always_comb begin
		an_d.analog_channel_zero = (c3 == PFM_CODE_3);
		an_d.analog_channel_one = (c2 == PFM_CODE_3);
		an_d.vref_in = (c1 == PFM_CODE_3);
		an_d.analog_channel_two = (c0 == PFM_CODE_3);
		an_d.gate_driver_input_zero = (c7 == PFM_CODE_3);
		an_d.gate_driver_input_one = (c5 == PFM_CODE_3);
	end

	// Read mux; unmapped addresses read zero
	always_comb begin
		unique case (bus_in.addr)
			PFM_ADDR_DATA: rdata_d = port_view(data_q, dir_q, pin_s);
			PFM_ADDR_DIR: rdata_d = dir_q;
			PFM_ADDR_WAKE: rdata_d = wake_q;
			PFM_ADDR_SEL_LO: rdata_d = sel_lo_q;
			PFM_ADDR_SEL_HI: rdata_d = sel_hi_q;
			PFM_ADDR_SRC: rdata_d = src_q;
			PFM_ADDR_STATUS: rdata_d = pin_s;
			default: rdata_d = 8'h00;
		endcase
	end

	// Registered read data; held zero outside a read answer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rdata <= 8'h00;
		end else if (bus_in.rd) begin
			rdata <= rdata_d;
		end else begin
			rdata <= 8'h00;
		end
	end

	// Registered pad and peripheral outputs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_out <= PFM_RST_DATA;
			pin_oe <= 8'h00;
			periph_in <= '1;
			analog_sel <= '0;
		end else begin
			pin_out <= drive_d;
			pin_oe <= oe_d;
			periph_in <= pin_d;
			analog_sel <= an_d;
		end
	end

	// Falling edge on an enabled general input wakes the core
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_prev_q <= 8'hFF;
			wake_req <= 1'b0;
		end else begin
			pin_prev_q <= pin_s;
			wake_req <= low_power_mode &&
				|(pin_prev_q & ~pin_s & wake_q & gpio_en & dir_q);
		end
	end
endmodule // pfm_top
`default_nettype wire

// >>> src/pfm_pkg.sv
// Contract
// - low select bits 7:6 route pin three
// - low select bits 5:4 route pin two
// - low select bits 3:2 route pin one
// - low select bits 1:0 route pin zero
// - pin seven code 11 is gate input 0
// - pin six code 11 reserved, else I/O
// - pin five code 11 is gate input 1
// - high select bits 1:0 route pin four
// - source bit 1 picks receive pin
// - source bit 0 picks filter pin
// - source bits 7:2 ignore writes, read zero
// - reset sets data and direction to ones
// - output without data write drives high
// - bit set/clear is read-modify-write
// - enabled pin falling edge wakes from sleep
// - direction one is input, zero push-pull output
package pfm_pkg;
	localparam logic [3:0] PFM_ADDR_DATA = 4'h0;
	localparam logic [3:0] PFM_ADDR_DIR = 4'h1;
	localparam logic [3:0] PFM_ADDR_WAKE = 4'h2;
	localparam logic [3:0] PFM_ADDR_SEL_LO = 4'h3;
	localparam logic [3:0] PFM_ADDR_SEL_HI = 4'h4;
	localparam logic [3:0] PFM_ADDR_SRC = 4'h5;
	localparam logic [3:0] PFM_ADDR_BITOP = 4'h6;
	localparam logic [3:0] PFM_ADDR_STATUS = 4'h7;
	localparam logic [7:0] PFM_RST_DATA = 8'hFF;
	localparam logic [7:0] PFM_RST_DIR = 8'hFF;
	localparam logic [7:0] PFM_RST_WAKE = 8'h00;
	localparam logic [7:0] PFM_RST_SEL = 8'h00;
	localparam logic [7:0] PFM_RST_SRC = 8'h00;
	localparam logic [7:0] PFM_SRC_MASK = 8'h03;
	localparam int PFM_SRC_RX_BIT = 1;
	localparam int PFM_SRC_NF_BIT = 0;
	// Bit-op word: bit 7 set(1)/clear(0), bits 4:3 target, bits 2:0 bit
	localparam int PFM_BITOP_SET = 7;
	localparam logic [1:0] PFM_TGT_DATA = 2'h0;
	localparam logic [1:0] PFM_TGT_DIR = 2'h1;
	localparam logic [1:0] PFM_TGT_WAKE = 2'h2;
	localparam logic [1:0] PFM_CODE_GPIO = 2'h0;
	localparam logic [1:0] PFM_CODE_1 = 2'h1;
	localparam logic [1:0] PFM_CODE_2 = 2'h2;
	localparam logic [1:0] PFM_CODE_3 = 2'h3;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pfm_bus_type;

	// Peripheral outputs that may be steered onto pins
	typedef struct packed {
		logic serial_tx;
		logic standard_timer_out;
		logic standard_timer_out_inverted;
		logic compact_timer_out;
		logic compact_timer_out_inverted;
	} pfm_periph_out_type;

	// Digital inputs fed from pins toward peripherals
	typedef struct packed {
		logic periodic_timer_capture_in;
		logic standard_timer_capture_in;
		logic standard_timer_clock_in;
		logic compact_timer_clock_in;
		logic noise_filter_input;
		logic ext_interrupt_in;
		logic serial_rx;
	} pfm_periph_in_type;

	// Analogue and gate-driver connection enables
	typedef struct packed {
		logic analog_channel_zero;
		logic analog_channel_one;
		logic analog_channel_two;
		logic vref_in;
		logic gate_driver_input_zero;
		logic gate_driver_input_one;
	} pfm_analog_type;
endpackage

// >>> src/pfm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pfm_sync
	import pfm_pkg::*;
#(
	parameter int WIDTH = 8
) (
	input wire logic ref_clk, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [WIDTH-1:0] async_in, // Pin levels
	output logic [WIDTH-1:0] sync_out // Synchronised levels
);
	logic [WIDTH-1:0] meta_q;

	// Two stages; pins idle high so reset to ones avoids false edges
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			meta_q <= '1;
			sync_out <= '1;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // pfm_sync
`default_nettype wire

// >>> verif/pfm_pads.sv
`timescale 1ns/10ps
`default_nettype none
module pfm_pads (
	input wire logic [7:0] pin_out, // Pad drive level
	input wire logic [7:0] pin_oe, // Pad drive enable
	input wire logic [7:0] ext, // Level the board imposes
	output logic [7:0] pin_in // Level seen on the pads
);
	// A driven pad shows the chip level, the rest what the board holds
	assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // pfm_pads
`default_nettype wire

// >>> verif/pfm_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pfm_chk
	import pfm_pkg::*;
(
	input wire logic ref_clk, // Clock
	input wire logic sys_rst, // Reset
	input wire pfm_bus_type bus_in, // Requests
	input wire logic [7:0] rdata, // Read data
	input wire logic [7:0] pin_in, // Pad levels
	input wire logic low_power_mode, // Sleep flag
	input wire logic wake_req, // Wake pulse
	input wire pfm_analog_type analog_sel // Switches
);
	logic [7:0] lo_q, hi_q, src_q;

	// Shadow selects; the switches lag them by one edge
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lo_q <= 8'h00;
			hi_q <= 8'h00;
			src_q <= 8'h00;
		end else if (bus_in.wr) begin
			if (bus_in.addr == PFM_ADDR_SEL_LO) lo_q <= bus_in.wdata;
			if (bus_in.addr == PFM_ADDR_SEL_HI) hi_q <= bus_in.wdata;
			if (bus_in.addr == PFM_ADDR_SRC) src_q <= bus_in.wdata & 8'h03;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	chk_pin3_adc: assert property (
		analog_sel.analog_channel_zero == ($past(lo_q[7:6]) == 2'h3))
		else $error("pin three analog switch wrong");
	chk_pin2_adc: assert property (
		analog_sel.analog_channel_one == ($past(lo_q[5:4]) == 2'h3))
		else $error("pin two analog switch wrong");
	chk_pin1_vref: assert property (
		analog_sel.vref_in == ($past(lo_q[3:2]) == 2'h3))
		else $error("pin one reference switch wrong");
	chk_pin0_adc: assert property (
		analog_sel.analog_channel_two == ($past(lo_q[1:0]) == 2'h3))
		else $error("pin zero analog switch wrong");
	chk_pin7_gate: assert property (
		analog_sel.gate_driver_input_zero == ($past(hi_q[7:6]) == 2'h3))
		else $error("pin seven gate switch wrong");
	chk_src_read: assert property (
		bus_in.rd && bus_in.addr == PFM_ADDR_SRC |=> rdata == src_q)
		else $error("source read wrong");
	chk_wake_awake: assert property (
		!$past(low_power_mode) && !$past(low_power_mode, 2) |-> !wake_req)
		else $error("wake outside low power");
	// Two pins may fall on neighbouring edges; only then may it last
	chk_wake_pulse: assert property (
		wake_req && !(|($past(pin_in, 3) & ~$past(pin_in, 2)))
		|=> !wake_req)
		else $error("wake pulse too long");
	// Sync stages plus the edge register put the fall four edges back
	chk_wake_cause: assert property (
		wake_req |-> |($past(pin_in, 4) & ~$past(pin_in, 3)))
		else $error("wake without a pad fall");
endmodule // pfm_chk
bind pfm_top pfm_chk chk (.ref_clk, .sys_rst, .bus_in, .rdata, .pin_in,
	.low_power_mode, .wake_req, .analog_sel);
`default_nettype wire

// >>> verif/pfm_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module pfm_top_bench
	import pfm_pkg::*;
;
	logic ref_clk, sys_rst, low_power_mode, wake_req;
	logic [7:0] rdata, pin_in, pin_out, pin_oe, ext, lo, hi, m, oe, o, seen;
	logic [15:0] lfsr = 16'h5EDC;
	pfm_bus_type bus_in;
	pfm_periph_out_type periph_out;
	pfm_periph_in_type periph_in;
	pfm_analog_type analog_sel;
	int n_fail = 0;
	int n_tests = 0;

	pfm_top DUT (.ref_clk, .sys_rst, .bus_in, .rdata, .pin_in, .pin_out,
		.pin_oe, .low_power_mode, .wake_req, .periph_out, .periph_in,
		.analog_sel);
	pfm_pads pads (.pin_out, .pin_oe, .ext, .pin_in);

	// Free-running 125 MHz clock
	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end

	function automatic logic [15:0] step(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	// Expected pads with every direction bit at output: {care, oe, level}
	// Receive and gate codes are left out, their drive is not fixed
	function automatic logic [23:0] pads_exp(logic [7:0] l, logic [7:0] h,
		logic [7:0] d, pfm_periph_out_type p);
		logic [7:0] c, e, v;
		c = 8'hFF;
		e = 8'hFF;
		v = d;
		if (l[7:6] == 2'h2) v[3] = p.serial_tx;
		if (l[7:6] == 2'h3) e[3] = 1'h0;
		if (l[5:4] == 2'h1) v[2] = p.standard_timer_out;
		if (l[5:4] == 2'h2) v[2] = p.standard_timer_out_inverted;
		if (l[5:4] == 2'h3) e[2] = 1'h0;
		if (l[3:2] == 2'h1) v[1] = p.serial_tx;
		if (l[3:2] == 2'h2) c[1] = 1'h0;
		if (l[3:2] == 2'h3) e[1] = 1'h0;
		if (l[1:0] == 2'h1) v[0] = p.compact_timer_out;
		if (l[1:0] == 2'h2) v[0] = p.compact_timer_out_inverted;
		if (l[1:0] == 2'h3) e[0] = 1'h0;
		if (h[1:0] == 2'h1) c[4] = 1'h0;
		if (h[1:0] == 2'h2) v[4] = p.compact_timer_out_inverted;
		if (h[3:2] == 2'h3) c[5] = 1'h0;
		if (h[7:6] == 2'h3) c[7] = 1'h0;
		return {c, e, v};
	endfunction

	task automatic check(logic [7:0] got, logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask

	// One-cycle strobe, then idle; returns just after the taking edge
	task automatic bus(logic [3:0] a, logic [7:0] d, logic w);
		@(posedge ref_clk);
		bus_in <= '{a, d, w, !w};
		@(posedge ref_clk);
		bus_in <= '0;
		#1;
	endtask

	task automatic rd(logic [3:0] a, logic [7:0] e);
		bus(a, 8'h00, 1'h0);
		check(rdata, e);
	endtask

	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// Drop the pads to v after a settled high and count wake pulses
	task automatic fall(logic [7:0] v, logic [7:0] n);
		int hits;
		hits = 0;
		ext <= 8'hFF;
		tick(3);
		ext <= v;
		repeat (8) begin
			tick(1);
			if (wake_req === 1'h1) hits++;
		end
		check(8'(hits), n);
	endtask

	task automatic stop_test;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		sys_rst = 1'h1;
		bus_in = '0;
		low_power_mode = 1'h0;
		ext = 8'hFF;
		periph_out = '0;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'h0;
		tick(1);
		check(pin_out, 8'hFF);
		check(pin_oe, 8'h00);
		rd(PFM_ADDR_DIR, 8'hFF);
		rd(PFM_ADDR_DATA, 8'hFF);
		rd(PFM_ADDR_SEL_HI, 8'h00);
		rd(4'hF, 8'h00);
		bus(PFM_ADDR_SRC, 8'hFF, 1'h1);
		rd(PFM_ADDR_SRC, 8'h03);
		bus(PFM_ADDR_DIR, 8'h00, 1'h1);
		tick(1);
		check(pin_oe, 8'hFF);
		check(pin_out, 8'hFF);
		// Random selects and peripheral levels with every direction bit at output
		for (int i = 0; i < 40; i++) begin
			lfsr = step(lfsr);
			lo = lfsr[7:0];
			hi = lfsr[15:8];
			lfsr = step(lfsr);
			periph_out <= '0;
			bus(PFM_ADDR_SEL_LO, lo, 1'h1);
			bus(PFM_ADDR_SEL_HI, hi, 1'h1);
			periph_out <= lfsr[12:8];
			bus(PFM_ADDR_DATA, lfsr[7:0], 1'h1);
			tick(1);
			{m, oe, o} = pads_exp(lo, hi, lfsr[7:0], periph_out);
			check(pin_oe & m, oe & m);
			check(pin_out & m & oe, o & m & oe);
			o = {2'h0, lo[7:6] == 2'h3, lo[5:4] == 2'h3,
				lo[1:0] == 2'h3, lo[3:2] == 2'h3,
				hi[7:6] == 2'h3, hi[3:2] == 2'h3};
			check({2'h0, analog_sel}, o);
			rd(PFM_ADDR_DATA, lfsr[7:0]);
		end
		// Receive and filter source steering with pins as inputs
		bus(PFM_ADDR_DIR, 8'hFF, 1'h1);
		for (int i = 0; i < 24; i++) begin
			lfsr = step(lfsr);
			lo = {4'h0, lfsr[0], 1'h0, lfsr[1], lfsr[1]};
			hi = {7'h0, lfsr[2]};
			ext <= lfsr[15:8];
			bus(PFM_ADDR_SEL_LO, lo, 1'h1);
			bus(PFM_ADDR_SEL_HI, hi, 1'h1);
			bus(PFM_ADDR_SRC, {6'h0, lfsr[4:3]}, 1'h1);
			tick(3);
			o[1] = lfsr[4] ? (hi[0] ? ext[4] : 1'h1) : (lo[3] ? ext[1] : 1'h1);
			o[0] = lfsr[3] ? (lo[0] ? 1'h1 : ext[0]) : (lo[3] ? 1'h1 : ext[1]);
			seen = {6'h0, periph_in.serial_rx, periph_in.noise_filter_input};
			check(seen, {6'h0, o[1:0]});
			// Capture, clock and interrupt inputs follow code 00 only
			o = {3'h0, ext[3], ext[2], (lo[3] ? 1'h1 : ext[1]),
				(hi[0] ? 1'h1 : ext[4]), (lo[0] ? 1'h1 : ext[0])};
			seen = {3'h0, periph_in.periodic_timer_capture_in,
				periph_in.standard_timer_capture_in,
				periph_in.standard_timer_clock_in,
				periph_in.compact_timer_clock_in, periph_in.ext_interrupt_in};
			check(seen, o);
		end
		// Bit set must merge the pad levels, not the stale latch
		bus(PFM_ADDR_SEL_LO, 8'h00, 1'h1);
		bus(PFM_ADDR_SEL_HI, 8'h00, 1'h1);
		bus(PFM_ADDR_DATA, 8'h00, 1'h1);
		ext <= 8'hA5;
		tick(3);
		rd(PFM_ADDR_STATUS, 8'hA5);
		bus(PFM_ADDR_BITOP, 8'h81, 1'h1);
		bus(PFM_ADDR_BITOP, 8'h0A, 1'h1);
		tick(1);
		check(pin_oe, 8'h04);
		bus(PFM_ADDR_DIR, 8'h00, 1'h1);
		tick(1);
		check(pin_out, 8'hA7);
		// Wake only for an enabled pin while asleep
		bus(PFM_ADDR_DIR, 8'hFF, 1'h1);
		bus(PFM_ADDR_WAKE, 8'h06, 1'h1);
		bus(PFM_ADDR_BITOP, 8'h11, 1'h1);
		rd(PFM_ADDR_WAKE, 8'h04);
		low_power_mode <= 1'h1;
		fall(8'hFB, 8'h01);
		fall(8'hF7, 8'h00);
		low_power_mode <= 1'h0;
		fall(8'hFB, 8'h00);
		// Second reset in mid-run
		sys_rst <= 1'h1;
		tick(2);
		sys_rst <= 1'h0;
		tick(1);
		check(pin_out, 8'hFF);
		rd(PFM_ADDR_WAKE, 8'h00);
		stop_test;
	end
endmodule // pfm_top_bench
`default_nettype wire
